// File: logic/pwp_host.sv
// Purpose: Host controller for protected page write and end-of-write polling
// Assumes: CE high time of one strobe covers the device's minimum pulse high
// Notes:   Page bytes held in flip-flops; one write request loads a page
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ns
module pwp_host #(
    parameter int          PROG_TIMEOUT = pwp_pkg::PROG_CYCLE_CYC,
    parameter logic [14:0] UNLOCK_ADDR0 = pwp_pkg::UNLK_A0,
    parameter logic [14:0] UNLOCK_ADDR1 = pwp_pkg::UNLK_A1,
    parameter logic [14:0] UNLOCK_ADDR2 = pwp_pkg::UNLK_A2,
    parameter logic [7:0]  UNLOCK_DATA0 = pwp_pkg::UNLK_D0,
    parameter logic [7:0]  UNLOCK_DATA1 = pwp_pkg::UNLK_D1,
    parameter logic [7:0]  UNLOCK_DATA2 = pwp_pkg::UNLK_D2
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        FILL_VALID,
    input  wire logic [6:0]  FILL_OFFSET,
    input  wire logic [7:0]  FILL_DATA,
    input  wire logic        WR_START,
    input  wire logic [9:0]  WR_PAGE,
    input  wire logic        WR_POLL_TOGGLE,
    input  wire logic        RD_START,
    input  wire logic [16:0] RD_ADDR,
    output logic             BUSY,
    output logic             WR_DONE,
    output logic             WR_TIMEOUT,
    output logic             RD_VALID,
    output logic [7:0]       RD_DATA,
    output logic [16:0]      MEM_ADDR,
    output logic [7:0]       MEM_DQ_OUT,
    output logic             MEM_DQ_OE_N,
    input  wire logic [7:0]  MEM_DQ_IN,
    output logic             MEM_CE_N,
    output logic             MEM_OE_N,
    output logic             MEM_WE_N
);
    // ------------------------------------------------------------
    // Page staging
    // ------------------------------------------------------------
    logic [7:0]                     page_mem [pwp_pkg::PAGE_BYTES];
    logic [pwp_pkg::PAGE_BYTES-1:0] used_ff;
    logic [7:0]                     dq_s1_ff;
    logic [7:0]                     dq_s2_ff;
    // ------------------------------------------------------------
    // Sequencer state
    // ------------------------------------------------------------
    pwp_pkg::pwp_state_e            state_ff;
    logic [9:0]                     page_ff;
    logic                           toggle_mode_ff;
    logic [1:0]                     step_ff;
    logic [7:0]                     idx_ff;
    logic [16:0]                    poll_addr_ff;
    logic [7:0]                     last_data_ff;
    logic                           prev_bit_ff;
    logic                           have_prev_ff;
    logic                           issued_ff;
    logic                           is_read_ff;
    logic [pwp_pkg::TMR_W-1:0]      tmr_ff;
    logic                           sb_go_ff;
    logic                           sb_wr_ff;
    logic                           sb_busy;
    logic                           sb_done;
    logic                           sb_drive;
    logic                           sb_ready;
    logic                           issue_unlock;
    logic                           issue_load;
    logic                           issue_rd;
    logic                           poll_hit;
    logic                           poll_expired;

    localparam logic [pwp_pkg::TMR_W-1:0] TMO_LIMIT = PROG_TIMEOUT[pwp_pkg::TMR_W-1:0];

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [16:0] unlock_addr(input logic [1:0] step);
        case (step)
            2'h0:    unlock_addr = {2'h0, UNLOCK_ADDR0};
            2'h1:    unlock_addr = {2'h0, UNLOCK_ADDR1};
            default: unlock_addr = {2'h0, UNLOCK_ADDR2};
        endcase
    endfunction : unlock_addr

    function automatic logic [7:0] unlock_data(input logic [1:0] step);
        case (step)
            2'h0:    unlock_data = UNLOCK_DATA0;
            2'h1:    unlock_data = UNLOCK_DATA1;
            default: unlock_data = UNLOCK_DATA2;
        endcase
    endfunction : unlock_data

    // Toggle mode never trusts a level, only a toggle bit left unchanged between two reads
    function automatic logic poll_finished(input logic       toggle,
                                           input logic       have_prev,
                                           input logic       prev,
                                           input logic [7:0] rd,
                                           input logic [7:0] last);
        if (toggle) begin
            poll_finished = have_prev && (rd[pwp_pkg::TOGGLE_BIT] == prev);
        end else begin
            poll_finished = rd[pwp_pkg::POLL_BIT] == last[pwp_pkg::POLL_BIT];
        end
    endfunction : poll_finished

    // ------------------------------------------------------------
    // Strobe engine
    // ------------------------------------------------------------
    pwp_strobe u_pwp_strobe (
        .clk      (CLOCK),
        .rst      (RST),
        .go       (sb_go_ff),
        .is_write (sb_wr_ff),
        .busy     (sb_busy),
        .done     (sb_done),
        .ce_n     (MEM_CE_N),
        .oe_n     (MEM_OE_N),
        .we_n     (MEM_WE_N),
        .drive    (sb_drive)
    );

    // Go pulse lands a cycle before busy, so it blocks a second issue
    assign sb_ready     = !sb_busy && !sb_go_ff;
    assign issue_unlock = (state_ff == pwp_pkg::ST_UNLOCK) && sb_ready && (step_ff != 2'h3);
    assign issue_load   = (state_ff == pwp_pkg::ST_LOAD) && sb_ready && !idx_ff[7] && used_ff[idx_ff[6:0]];
    assign issue_rd     = sb_ready && (((state_ff == pwp_pkg::ST_POLL) && !poll_expired)
                                       || ((state_ff == pwp_pkg::ST_READ) && !issued_ff));
    assign poll_hit     = sb_done && poll_finished(toggle_mode_ff, have_prev_ff, prev_bit_ff, dq_s2_ff,
                                                   last_data_ff);
    assign poll_expired = (state_ff == pwp_pkg::ST_POLL) && !sb_done && (tmr_ff >= TMO_LIMIT);

    // ------------------------------------------------------------
    // Pin data synchroniser
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            dq_s1_ff <= 8'h00;
            dq_s2_ff <= 8'h00;
        end else begin
            dq_s1_ff <= MEM_DQ_IN;
            dq_s2_ff <= dq_s1_ff;
        end
    end

    // ------------------------------------------------------------
    // Page buffer fill, only while idle
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK) begin
        if (FILL_VALID && (state_ff == pwp_pkg::ST_IDLE)) page_mem[FILL_OFFSET] <= FILL_DATA;
    end

    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            used_ff <= {pwp_pkg::PAGE_BYTES{1'b0}};
        end else begin
            if (issue_load) used_ff[idx_ff[6:0]] <= 1'b0;
            if (FILL_VALID && (state_ff == pwp_pkg::ST_IDLE)) used_ff[FILL_OFFSET] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Bus request registers
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            MEM_ADDR    <= 17'h00000;
            MEM_DQ_OUT  <= 8'h00;
            MEM_DQ_OE_N <= 1'b1;
            sb_go_ff    <= 1'b0;
            sb_wr_ff    <= 1'b0;
        end else begin
            sb_go_ff    <= issue_unlock || issue_load || issue_rd;
            MEM_DQ_OE_N <= ~sb_drive;
            if (issue_unlock) begin
                MEM_ADDR   <= unlock_addr(step_ff);
                MEM_DQ_OUT <= unlock_data(step_ff);
                sb_wr_ff   <= 1'b1;
            end else if (issue_load) begin
                MEM_ADDR   <= {page_ff, idx_ff[6:0]};
                MEM_DQ_OUT <= page_mem[idx_ff[6:0]];
                sb_wr_ff   <= 1'b1;
            end else if (issue_rd) begin
                MEM_ADDR   <= poll_addr_ff;
                sb_wr_ff   <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            state_ff       <= pwp_pkg::ST_IDLE;
            page_ff        <= 10'h000;
            toggle_mode_ff <= 1'b0;
            step_ff        <= 2'h0;
            idx_ff         <= 8'h00;
            poll_addr_ff   <= 17'h00000;
            last_data_ff   <= 8'h00;
            prev_bit_ff    <= 1'b0;
            have_prev_ff   <= 1'b0;
            issued_ff      <= 1'b0;
            is_read_ff     <= 1'b0;
            tmr_ff         <= {pwp_pkg::TMR_W{1'b0}};
        end else begin
            case (state_ff)
                pwp_pkg::ST_IDLE: begin
                    step_ff   <= 2'h0;
                    idx_ff    <= 8'h00;
                    issued_ff <= 1'b0;
                    if (WR_START) begin
                        page_ff        <= WR_PAGE;
                        toggle_mode_ff <= WR_POLL_TOGGLE;
                        is_read_ff     <= 1'b0;
                        // Empty page skips the bus: an unguarded cycle would lock the part
                        if (used_ff == {pwp_pkg::PAGE_BYTES{1'b0}}) state_ff <= pwp_pkg::ST_DONE;
                        else state_ff <= pwp_pkg::ST_UNLOCK;
                    end else if (RD_START) begin
                        poll_addr_ff <= RD_ADDR;
                        is_read_ff   <= 1'b1;
                        state_ff     <= pwp_pkg::ST_READ;
                    end
                end
                pwp_pkg::ST_UNLOCK: begin
                    if (issue_unlock) step_ff <= step_ff + 2'h1;
                    if ((step_ff == 2'h3) && sb_ready) state_ff <= pwp_pkg::ST_LOAD;
                end
                pwp_pkg::ST_LOAD: begin
                    // One slot per cycle keeps the load gap far below the window
                    if (issue_load) begin
                        poll_addr_ff <= {page_ff, idx_ff[6:0]};
                        last_data_ff <= page_mem[idx_ff[6:0]];
                    end
                    if (sb_ready) begin
                        if (idx_ff[7]) state_ff <= pwp_pkg::ST_WAIT;
                        else idx_ff <= idx_ff + 8'h01;
                    end
                end
                pwp_pkg::ST_WAIT: begin
                    tmr_ff       <= {pwp_pkg::TMR_W{1'b0}};
                    have_prev_ff <= 1'b0;
                    state_ff     <= pwp_pkg::ST_POLL;
                end
                pwp_pkg::ST_POLL: begin
                    tmr_ff <= tmr_ff + {{(pwp_pkg::TMR_W-1){1'b0}}, 1'b1};
                    if (sb_done) begin
                        prev_bit_ff  <= dq_s2_ff[pwp_pkg::TOGGLE_BIT];
                        have_prev_ff <= 1'b1;
                        if (poll_hit) state_ff <= pwp_pkg::ST_DONE;
                    end else if (poll_expired) begin
                        state_ff <= pwp_pkg::ST_DONE;
                    end
                end
                pwp_pkg::ST_READ: begin
                    if (issue_rd) issued_ff <= 1'b1;
                    if (sb_done) state_ff <= pwp_pkg::ST_DONE;
                end
                pwp_pkg::ST_DONE: begin
                    // Last strobe's high time must run out before the next access
                    if (sb_ready) state_ff <= pwp_pkg::ST_IDLE;
                end
                default: state_ff <= pwp_pkg::ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Status outputs
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            BUSY       <= 1'b0;
            WR_DONE    <= 1'b0;
            WR_TIMEOUT <= 1'b0;
            RD_VALID   <= 1'b0;
            RD_DATA    <= 8'h00;
        end else begin
            WR_DONE  <= (state_ff == pwp_pkg::ST_DONE) && sb_ready && !is_read_ff;
            RD_VALID <= (state_ff == pwp_pkg::ST_DONE) && sb_ready && is_read_ff;
            if (state_ff == pwp_pkg::ST_IDLE) BUSY <= WR_START || RD_START;
            else if ((state_ff == pwp_pkg::ST_DONE) && sb_ready) BUSY <= 1'b0;
            else BUSY <= 1'b1;
            if ((state_ff == pwp_pkg::ST_READ) && sb_done) RD_DATA <= dq_s2_ff;
            if ((state_ff == pwp_pkg::ST_IDLE) && WR_START) WR_TIMEOUT <= 1'b0;
            else if (poll_expired) WR_TIMEOUT <= 1'b1;
        end
    end
endmodule : pwp_host

// File: logic/pwp_pkg.sv
// Purpose: Constants for the protected page-write host controller
// Assumes: 100 MHz CLOCK
// Notes:   Timing figures kept in their own units, cycle counts derived
package pwp_pkg;
    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int PROG_CYCLE_MS     = 10;
    localparam int BYTE_LOAD_US      = 150;
    localparam int CE_HIGH_NS        = 50;
    localparam int WR_PULSE_NS       = 200;
    localparam int WR_HIGH_NS        = 100;
    localparam int ADDR_HOLD_NS      = 100;
    localparam int RD_ACCESS_NS      = 200;
    localparam int OE_HIGH_PULSE_NS  = 150;
    // Least times round up
    localparam int PROG_CYCLE_CYC    = (PROG_CYCLE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CE_HIGH_CYC       = (CE_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_PULSE_CYC      = (WR_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WR_HIGH_CYC       = (WR_HIGH_NS + ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RD_ACCESS_CYC     = (RD_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 2;
    localparam int OE_HIGH_CYC       = (OE_HIGH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Longest time rounds down
    localparam int BYTE_LOAD_CYC     = (BYTE_LOAD_US * 1000) / CLK_PERIOD_NS;
    // ------------------------------------------------------------
    // Widths and fields
    // ------------------------------------------------------------
    localparam int ADDR_W            = 17;
    localparam int PAGE_BYTES        = 128;
    localparam int PAGE_LSB          = 7;
    localparam int POLL_BIT          = 7;
    localparam int TOGGLE_BIT        = 6;
    localparam int TMR_W             = 24;
    // Unlock sequence defaults, arbitrary, override per part
    localparam logic [14:0] UNLK_A0  = 15'h5555;
    localparam logic [14:0] UNLK_A1  = 15'h2AAA;
    localparam logic [14:0] UNLK_A2  = 15'h5555;
    localparam logic [7:0]  UNLK_D0  = 8'hAA;
    localparam logic [7:0]  UNLK_D1  = 8'h55;
    localparam logic [7:0]  UNLK_D2  = 8'hA0;
    // Poll method
    localparam logic        POLL_TOGGLE = 1'b1;
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h0,
        ST_UNLOCK = 4'h1,
        ST_LOAD   = 4'h3,
        ST_WAIT   = 4'h2,
        ST_POLL   = 4'h6,
        ST_DONE   = 4'h7,
        ST_READ   = 4'h5
    } pwp_state_e;
endpackage : pwp_pkg

// File: logic/pwp_strobe.sv
// Purpose: One bus cycle on the parallel pins, write or read
// Assumes: Caller holds address and data stable while busy
// Notes:   Write uses WE as strobe, CE rises a cycle after WE; read drops OE a cycle after CE
`timescale 1ns/1ns
module pwp_strobe (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        go,
    input  wire logic        is_write,
    output logic             busy,
    output logic             done,
    output logic             ce_n,
    output logic             oe_n,
    output logic             we_n,
    output logic             drive
);
    // ------------------------------------------------------------
    // Phase counter
    // ------------------------------------------------------------
    logic [7:0] cnt_ff;
    logic       wr_ff;
    logic [1:0] ph_ff;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ph_ff  <= 2'h0;
            cnt_ff <= 8'h00;
            wr_ff  <= 1'b0;
            ce_n   <= 1'b1;
            oe_n   <= 1'b1;
            we_n   <= 1'b1;
            drive  <= 1'b0;
            done   <= 1'b0;
        end else begin
            done <= 1'b0;
            case (ph_ff)
                2'h0: begin
                    if (go) begin
                        wr_ff <= is_write;
                        ph_ff <= 2'h1;
                        ce_n  <= 1'b0;
                        drive <= is_write;
                        oe_n  <= 1'b1;
                        we_n  <= ~is_write;
                        cnt_ff <= is_write ? 8'(pwp_pkg::WR_PULSE_CYC) : 8'(pwp_pkg::RD_ACCESS_CYC);
                    end
                end
                2'h1: begin
                    if (cnt_ff == 8'h01) begin
                        // CE held low past the WE edge so the write latches on WE alone
                        oe_n   <= 1'b1;
                        we_n   <= 1'b1;
                        ph_ff  <= 2'h2;
                        // CE high time also covers OE high pulse and address hold
                        cnt_ff <= wr_ff ? 8'(pwp_pkg::WR_HIGH_CYC) : 8'(pwp_pkg::OE_HIGH_CYC);
                        done   <= 1'b1;
                    end else begin
                        cnt_ff <= cnt_ff - 8'h01;
                        // Single OE fall per read so one status read is one toggle step
                        if (!wr_ff) oe_n <= 1'b0;
                    end
                end
                2'h2: begin
                    ce_n  <= 1'b1;
                    drive <= 1'b0;
                    if (cnt_ff == 8'h01) ph_ff <= 2'h0;
                    else cnt_ff <= cnt_ff - 8'h01;
                end
                default: ph_ff <= 2'h0;
            endcase
        end
    end

    assign busy = (ph_ff != 2'h0);
endmodule : pwp_strobe

// File: test/pwp_host_sva.sv
// Purpose: Port checks for pwp_host
// Assumes: Default unlock values
// Notes:   Helper counts track strobes per busy span
`timescale 1ns/1ns
module pwp_host_sva (
    input wire logic        CLOCK, RST, BUSY, WR_DONE, MEM_DQ_OE_N, MEM_CE_N, MEM_OE_N, MEM_WE_N,
    input wire logic [16:0] MEM_ADDR,
    input wire logic [7:0]  MEM_DQ_OUT
);
    int          wn, gap;
    logic [9:0]  pg;
    logic [16:0] pa;
    logic        pv;
    wire logic [22:0] key = wn == 0 ? {pwp_pkg::UNLK_A0, pwp_pkg::UNLK_D0} : wn == 1 ?
                            {pwp_pkg::UNLK_A1, pwp_pkg::UNLK_D1} : {pwp_pkg::UNLK_A2, pwp_pkg::UNLK_D2};
    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);
    always_ff @(posedge CLOCK or posedge RST)
        if (RST) wn <= 0;
        else wn <= BUSY ? wn + int'($rose(MEM_WE_N)) : 0;
    // Poll address only compared once a poll read has been seen
    always_ff @(posedge CLOCK) begin
        gap <= $rose(MEM_WE_N) ? 0 : gap + 1;
        pv  <= BUSY && (pv || $fell(MEM_OE_N) && wn > 3);
        if (wn == 3) pg <= MEM_ADDR[16:7];
        if ($fell(MEM_OE_N)) pa <= MEM_ADDR;
    end
    chk_oe_write: assert property (!MEM_WE_N && !MEM_CE_N |-> MEM_OE_N) else $error("oe low in write");
    chk_ce_high: assert property ($rose(MEM_CE_N) |-> MEM_CE_N[*5]) else $error("ce high short");
    chk_dq_free: assert property (!MEM_OE_N |-> MEM_DQ_OE_N) else $error("dq driven in read");
    chk_unlock_seq: assert property ($rose(MEM_WE_N) && wn < 3 |-> {MEM_ADDR[14:0], MEM_DQ_OUT} == key)
        else $error("bad unlock");
    chk_page_same: assert property ($rose(MEM_WE_N) && wn > 3 |-> MEM_ADDR[16:7] == pg) else $error("page moved");
    chk_load_gap: assert property ($fell(MEM_WE_N) && wn > 0 |-> gap < pwp_pkg::BYTE_LOAD_CYC)
        else $error("load gap");
    chk_poll_addr: assert property ($fell(MEM_OE_N) && pv |-> MEM_ADDR == pa) else $error("poll addr");
    chk_poll_no_wr: assert property (pv |-> MEM_WE_N) else $error("write in poll");
    cover property (wn == 131);
    cover property ($fell(MEM_OE_N) && pv);
    cover property (WR_DONE);
endmodule : pwp_host_sva
bind pwp_host pwp_host_sva u_pwp_host_sva (.*);

// File: test/pwp_mem_model.sv
// Purpose: Protected-write memory model for pwp_host
// Assumes: WE controlled writes, default unlock values
// Notes:   Load window and program time shortened for run length
`timescale 1ns/1ns
module pwp_mem_model #(parameter int LOAD_CYC = 1000, parameter int PROG_CYC = 2000) (
    input wire logic        clk, ce_n, oe_n, we_n, dq_oe_n,
    input wire logic [16:0] addr,
    input wire logic [7:0]  dq_wr,
    output logic [7:0]      dq_rd
);
    logic [7:0] mem [logic [16:0]], pg [logic [6:0]], last = 8'h00;
    logic [9:0] pa;
    logic       tog = 1'b0;
    int         ul = 0, st = 0, tmr = 0;
    wire logic [22:0] key = ul == 0 ? {pwp_pkg::UNLK_A0, pwp_pkg::UNLK_D0} : ul == 1 ?
                            {pwp_pkg::UNLK_A1, pwp_pkg::UNLK_D1} : {pwp_pkg::UNLK_A2, pwp_pkg::UNLK_D2};
    initial dq_rd = 8'h00;
    always @(posedge we_n) if (!ce_n && oe_n && st != 2) begin
        if (ul == 3) begin
            pg[addr[6:0]] = dq_wr;
            pa = addr[16:7];
            last = dq_wr;
            st = 1;
            tmr = LOAD_CYC;
        end else if ({addr[14:0], dq_wr} == key) ul++;
        else begin
            {ul, st} = {32'd0, 32'd2};
            tmr = PROG_CYC;
        end
    end
    always @(posedge clk)
        if (tmr > 1) tmr--;
        else if (tmr == 1 && st == 1) begin
            st = 2;
            tmr = PROG_CYC;
        end else if (tmr == 1) begin
            foreach (pg[i]) mem[{pa, i}] = pg[i];
            pg.delete();
            {st, ul, tmr} = 96'd0;
        end
    always @(negedge oe_n or negedge ce_n) if (!ce_n && !oe_n && st != 0) tog = ~tog;
    // Released bus flips every cycle so stale data never looks valid
    always @(posedge clk) dq_rd <= !dq_oe_n ? dq_wr : ce_n || oe_n ? ~dq_rd : st != 0 ? {~last[7], tog, last[5:0]}
                                   : mem.exists(addr) ? mem[addr] : 8'hFF;
endmodule : pwp_mem_model

// File: test/tb_pwp_host.sv
// Purpose: Self-checking bench for pwp_host
// Assumes: Start and done are one-cycle pulses
// Notes:   Short program timeout keeps runs brief
`timescale 1ns/1ns
module tb_pwp_host;
    logic        CLOCK = 0, RST = 1, FILL_VALID = 0, WR_START = 0, WR_POLL_TOGGLE = 0, RD_START = 0;
    logic [6:0]  FILL_OFFSET = 0, o;
    logic [7:0]  FILL_DATA = 0, RD_DATA, MEM_DQ_OUT, MEM_DQ_IN, d;
    logic [9:0]  WR_PAGE = 0, p;
    logic [16:0] RD_ADDR = 0, MEM_ADDR;
    logic        BUSY, WR_DONE, WR_TIMEOUT, RD_VALID, MEM_DQ_OE_N, MEM_CE_N, MEM_OE_N, MEM_WE_N;
    int          mismatches = 0, samples_checked = 0, seed = 76690, t, i;
    logic [7:0]  ref_mem [logic [16:0]];
    always #5 CLOCK = ~CLOCK;
    pwp_host #(.PROG_TIMEOUT(20000)) u_pwp_host (.*);
    pwp_mem_model u_pwp_mem_model (.clk(CLOCK), .ce_n(MEM_CE_N), .oe_n(MEM_OE_N), .we_n(MEM_WE_N),
        .dq_oe_n(MEM_DQ_OE_N), .addr(MEM_ADDR), .dq_wr(MEM_DQ_OUT), .dq_rd(MEM_DQ_IN));
    task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : cmp
    task automatic await(ref logic s);
        repeat (30000) begin
            @(posedge CLOCK);
            #1;
            if (s === 1'b1) return;
        end
        cmp("handshake", 8'h01, 8'h00);
    endtask : await
    task automatic rd(input logic [16:0] a);
        @(posedge CLOCK);
        RD_START <= 1;
        RD_ADDR  <= a;
        @(posedge CLOCK);
        RD_START <= 0;
        await(RD_VALID);
        cmp("RD_DATA", ref_mem.exists(a) ? ref_mem[a] : 8'hFF, RD_DATA);
    endtask : rd
    task automatic test_done();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    initial begin
        repeat (6) @(posedge CLOCK);
        RST <= 0;
        for (t = 0; t < 4; t++) begin
            p = 10'(t * 3 + 1);
            for (i = 0; i < (t == 1 ? 128 : 1 + 3 * t); i++) begin
                o = t == 1 ? i[6:0] : 7'($random(seed));
                d = 8'($random(seed));
                ref_mem[{p, o}] = d;
                @(posedge CLOCK);
                FILL_VALID  <= 1;
                FILL_OFFSET <= o;
                FILL_DATA   <= d;
            end
            @(posedge CLOCK);
            FILL_VALID     <= 0;
            WR_START       <= 1;
            WR_PAGE        <= p;
            WR_POLL_TOGGLE <= t[0];
            @(posedge CLOCK);
            WR_START <= 0;
            await(WR_DONE);
            cmp("WR_TIMEOUT", 8'h00, {7'h00, WR_TIMEOUT});
            foreach (ref_mem[a]) rd(a);
            $display("test %0d done", t);
        end
        rd(17'h1FFFF);
        test_done();
    end
    initial begin
        repeat (90000) @(posedge CLOCK);
        mismatches++;
        test_done();
    end
endmodule : tb_pwp_host
